/* core/vec_addr_gen.sv */
// reset and interrupt vector address generator with timed table-select change
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module vec_addr_gen (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [31:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic boot_reset_select_fuse,
	input wire logic [vec_pkg::ADDR_W-1:0] boot_start_addr,
	input wire logic [vec_pkg::NUM_SRC-1:0] irq_request,
	input wire logic [vec_pkg::NUM_SRC-1:0] irq_enable,
	input wire logic global_irq_flag,
	input wire logic fetch_reset,
	input wire logic irq_take,
	input wire logic instr_done,
	output logic [vec_pkg::ADDR_W-1:0] fetch_addr,
	output logic fetch_valid,
	output logic [4:0] vector_number,
	output logic irq_pending,
	output logic irq_blocked
);
	import vec_pkg::*;

	// apb decode, shared by write and read paths
	function automatic logic is_reg(input logic [31:0] a, input logic [11:0] ofs);
		is_reg = (a[31:12] == 20'h00000) && (a[11:0] == ofs);
	endfunction : is_reg

	logic vector_table_select_r;
	logic vector_change_enable_r;
	logic [2:0] chg_count_r;
	chg_state_t chg_state_r;
	logic block_after_r;
	logic irq_blocked_r;
	logic [ADDR_W-1:0] fetch_addr_r;
	logic fetch_valid_r;
	logic [4:0] vector_number_r;
	logic irq_pending_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic boot_mode_r;

	logic access;
	logic ctrl_wr;
	logic wr_chg;
	logic wr_sel_phase;
	logic mapped;
	logic enc_found;
	logic [4:0] enc_index;
	logic [11:0] enc_offset;
	logic [ADDR_W-1:0] table_base;
	logic [ADDR_W-1:0] reset_addr;
	logic block_nxt;

	// transfers complete in their first access cycle, no wait states; a write lands
	// at the edge where the master samples pready high, never in the setup cycle
	assign access = psel && penable && pready_r;
	assign mapped = is_reg(paddr, REG_IRQ_CTRL) || is_reg(paddr, REG_STATUS) || is_reg(paddr, REG_PENDING);
	assign ctrl_wr = access && pwrite && is_reg(paddr, REG_IRQ_CTRL);
	assign wr_chg = ctrl_wr && pwdata[CTRL_CHG_BIT];
	// a write with change enable clear while armed is the select write
	assign wr_sel_phase = ctrl_wr && !pwdata[CTRL_CHG_BIT] && vector_change_enable_r;

	vec_encoder u_enc (
		.pending(irq_request & irq_enable),
		.found(enc_found),
		.index(enc_index),
		.offset(enc_offset)
	);

	// reset vector from the fuse alone; table base from the select bit alone
	assign reset_addr = (boot_mode_r) ? boot_start_addr : RESET_ADDR_APP;
	assign table_base = vector_table_select_r ? boot_start_addr : 12'h000;

	// fuse is caught by a clocked process after reset release, never in the async branch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_mode_r <= 1'b0;
		end else begin
			boot_mode_r <= (boot_reset_select_fuse != FUSE_UNPROGRAMMED);
		end
	end

	// apb handshake and error on unmapped addresses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= psel && !pready_r;
			pslverr_r <= psel && !pready_r && !mapped;
		end
	end

	// read data is registered so it stands with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (psel && !pready_r && !pwrite) begin
			if (is_reg(paddr, REG_IRQ_CTRL)) begin
				prdata_r <= {30'h0000_0000, vector_table_select_r, vector_change_enable_r};
			end else if (is_reg(paddr, REG_STATUS)) begin
				prdata_r <= {24'h00_0000, 1'b0, boot_mode_r, irq_blocked_r, enc_index};
			end else if (is_reg(paddr, REG_PENDING)) begin
				prdata_r <= {14'h0000, irq_request & irq_enable};
			end else begin
				prdata_r <= 32'h0000_0000;
			end
		end
	end

	// change-enable window: armed by a write with the bit set, closed after four cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vector_change_enable_r <= CTRL_RESET[CTRL_CHG_BIT];
			chg_count_r <= 3'h0;
		end else if (wr_chg) begin
			vector_change_enable_r <= 1'b1;
			chg_count_r <= CHANGE_WINDOW_CYC;
		end else if (wr_sel_phase) begin
			vector_change_enable_r <= 1'b0;
			chg_count_r <= 3'h0;
		end else if (chg_count_r != 3'h0) begin
			chg_count_r <= chg_count_r - 3'h1;
			if (chg_count_r == 3'h1) begin
				vector_change_enable_r <= 1'b0;
			end
		end
	end

	// select bit moves only through the timed sequence; plain writes leave it alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vector_table_select_r <= CTRL_RESET[CTRL_SEL_BIT];
		end else if (wr_sel_phase) begin
			vector_table_select_r <= pwdata[CTRL_SEL_BIT];
		end
	end

	// block state: armed until window ends or select written, then hold to next instruction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chg_state_r <= ST_IDLE;
		end else begin
			case (chg_state_r)
				ST_IDLE: begin
					if (wr_chg) begin
						chg_state_r <= ST_ARMED;
					end
				end
				ST_ARMED: begin
					if (wr_sel_phase) begin
						chg_state_r <= ST_HOLD;
					end else if (!wr_chg && chg_count_r == 3'h1) begin
						chg_state_r <= ST_IDLE;
					end
				end
				ST_HOLD: begin
					if (wr_chg) begin
						chg_state_r <= ST_ARMED;
					end else if (instr_done) begin
						chg_state_r <= ST_IDLE;
					end
				end
				default: begin
					chg_state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// block covers the arming cycle itself and the whole sequence; global flag untouched
	assign block_nxt = wr_chg || (chg_state_r == ST_ARMED && !(chg_count_r == 3'h1 && !wr_sel_phase))
		|| (chg_state_r == ST_HOLD && !instr_done) || wr_sel_phase;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_blocked_r <= 1'b0;
			block_after_r <= 1'b0;
		end else begin
			irq_blocked_r <= block_nxt;
			block_after_r <= irq_blocked_r;
		end
	end

	// pending indicator for the core: enabled, globally allowed and not blocked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pending_r <= 1'b0;
		end else begin
			irq_pending_r <= enc_found && global_irq_flag && !block_nxt;
		end
	end

	// fetch address: reset wins, otherwise a vector only when the core takes one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fetch_addr_r <= RESET_ADDR_APP;
			fetch_valid_r <= 1'b0;
			vector_number_r <= 5'h01;
		end else if (fetch_reset) begin
			fetch_addr_r <= reset_addr;
			fetch_valid_r <= 1'b1;
			vector_number_r <= 5'h01;
		end else if (irq_take && irq_pending_r && enc_found && !irq_blocked_r) begin
			fetch_addr_r <= table_base + enc_offset;
			fetch_valid_r <= 1'b1;
			vector_number_r <= enc_index + 5'h02;
		end else begin
			fetch_valid_r <= 1'b0;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign fetch_addr = fetch_addr_r;
	assign fetch_valid = fetch_valid_r;
	assign vector_number = vector_number_r;
	assign irq_pending = irq_pending_r;
	assign irq_blocked = irq_blocked_r;
endmodule : vec_addr_gen
`default_nettype wire

/* core/vec_pkg.sv */
// package: vector offsets, register layout and timing counts for the vector address generator
package vec_pkg;
	localparam int unsigned PCLK_HZ = 125000000;
	localparam int ADDR_W = 12;
	localparam int NUM_SRC = 18;
	localparam logic [11:0] RESET_ADDR_APP = 12'h000;
	localparam logic [11:0] TABLE_FIRST_OFS = 12'h001;
	localparam logic [11:0] OFS_EXT_ZERO = 12'h001;
	localparam logic [11:0] OFS_EXT_ONE = 12'h002;
	localparam logic [11:0] OFS_T2_COMP = 12'h003;
	localparam logic [11:0] OFS_T2_OVF = 12'h004;
	localparam logic [11:0] OFS_T1_CAPT = 12'h005;
	localparam logic [11:0] OFS_T1_COMPA = 12'h006;
	localparam logic [11:0] OFS_T1_COMPB = 12'h007;
	localparam logic [11:0] OFS_T1_OVF = 12'h008;
	localparam logic [11:0] OFS_T0_OVF = 12'h009;
	localparam logic [11:0] OFS_SPI_DONE = 12'h00A;
	localparam logic [11:0] OFS_RX_DONE = 12'h00B;
	localparam logic [11:0] OFS_TX_EMPTY = 12'h00C;
	localparam logic [11:0] OFS_TX_DONE = 12'h00D;
	localparam logic [11:0] OFS_CONV_DONE = 12'h00E;
	localparam logic [11:0] OFS_EEPROM_RDY = 12'h00F;
	localparam logic [11:0] OFS_COMPARATOR = 12'h010;
	localparam logic [11:0] OFS_TWO_WIRE = 12'h011;
	localparam logic [11:0] OFS_STORE_RDY = 12'h012;
	localparam logic FUSE_UNPROGRAMMED = 1'b1;
	// timed change window, in cycles
	localparam logic [2:0] CHANGE_WINDOW_CYC = 3'h4;
	// register map (byte addresses)
	localparam logic [11:0] REG_IRQ_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_PENDING = 12'h008;
	localparam int CTRL_CHG_BIT = 0;
	localparam int CTRL_SEL_BIT = 1;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	typedef struct packed {
		logic [11:0] addr;
		logic [4:0] number;
		logic valid;
	} vec_req_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARMED = 2'b01,
		ST_HOLD = 2'b10
	} chg_state_t;
endpackage : vec_pkg

/* core/vec_encoder.sv */
// lowest-number priority encoder mapping pending sources to table offsets
`timescale 1ns/10ps
`default_nettype none
module vec_encoder (
	input wire logic [vec_pkg::NUM_SRC-1:0] pending,
	output logic found,
	output logic [4:0] index,
	output logic [11:0] offset
);
	import vec_pkg::*;
	// offset of a slot is its index plus one
	function automatic logic [11:0] slot_offset(input logic [4:0] i);
		slot_offset = TABLE_FIRST_OFS + {7'h00, i};
	endfunction : slot_offset
	logic [NUM_SRC-1:0] lower_hit;
	genvar g;
	// a source wins only when no lower-numbered one is pending
	assign lower_hit[0] = 1'b0;
	generate
		for (g = 1; g < NUM_SRC; g++) begin : g_chain
			assign lower_hit[g] = lower_hit[g-1] | pending[g-1];
		end
	endgenerate
	always_comb begin
		found = |pending;
		index = 5'h00;
		for (int k = 0; k < NUM_SRC; k++) begin
			if (pending[k] && !lower_hit[k]) begin
				index = 5'(k);
			end
		end
		offset = slot_offset(index);
	end
endmodule : vec_encoder
`default_nettype wire

/* sim/vec_addr_gen_assertions.sv */
// checker: port assertions for the vector address generator
`timescale 1ns/10ps
`default_nettype none
module vec_addr_gen_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic boot_reset_select_fuse,
	input wire logic [11:0] boot_start_addr,
	input wire logic fetch_reset,
	input wire logic irq_take,
	input wire logic irq_pending,
	input wire logic irq_blocked,
	input wire logic [11:0] fetch_addr,
	input wire logic fetch_valid,
	input wire logic [4:0] vector_number
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// zero wait states: a setup cycle is answered in the access cycle
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	property p_rst_app; fetch_reset && boot_reset_select_fuse |=> fetch_valid && fetch_addr == 12'h000 && vector_number == 5'h01; endproperty
	a_rst_app: assert property (p_rst_app) else $error("reset fetch not at zero");
	property p_rst_boot; fetch_reset && !boot_reset_select_fuse |=> fetch_valid && fetch_addr == boot_start_addr; endproperty
	a_rst_boot: assert property (p_rst_boot) else $error("reset fetch not at boot start");
	property p_take; irq_take && irq_pending && !fetch_reset |=> fetch_valid; endproperty
	a_take: assert property (p_take) else $error("taken interrupt not fetched");
	property p_idle; !irq_take && !fetch_reset |=> !fetch_valid; endproperty
	a_idle: assert property (p_idle) else $error("fetch without request");
	// either table base: zero or boot start
	property p_slot; fetch_valid && vector_number != 5'h01 |-> fetch_addr == 12'(vector_number - 5'h01)
		|| fetch_addr == boot_start_addr + 12'(vector_number - 5'h01); endproperty
	a_slot: assert property (p_slot) else $error("vector slot address wrong");
	property p_block; irq_blocked && irq_take && !fetch_reset |=> !fetch_valid; endproperty
	a_block: assert property (p_block) else $error("interrupt taken while blocked");
	property p_block_len; $rose(irq_blocked) |-> ##[1:10] !irq_blocked; endproperty
	a_block_len: assert property (p_block_len) else $error("block never lifted");
	c_take: cover property (irq_take && irq_pending);
	c_block: cover property (irq_blocked && irq_take);
	c_boot: cover property (fetch_reset && !boot_reset_select_fuse);
endmodule : vec_addr_gen_chk
bind vec_addr_gen vec_addr_gen_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .boot_reset_select_fuse,
	.boot_start_addr, .fetch_reset, .irq_take, .irq_pending, .irq_blocked, .fetch_addr, .fetch_valid, .vector_number);
`default_nettype wire

/* sim/core_fetch_model.sv */
// core model: takes pending interrupts and retires instructions slowly
`timescale 1ns/10ps
`default_nettype none
module core_fetch_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic irq_pending,
	input wire logic eager,
	output logic irq_take,
	output logic instr_done
);
	logic [2:0] hold_r;
	logic [1:0] ins_r;
	// back off after a take so a stale pending level is not taken twice
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_take <= 1'b0;
			hold_r <= 3'h0;
		end else if (hold_r != 3'h0) begin
			irq_take <= 1'b0;
			hold_r <= hold_r - 3'h1;
		end else begin
			irq_take <= irq_pending || eager;
			hold_r <= (irq_pending || eager) ? 3'h4 : 3'h0;
		end
	end
	// one instruction retires every fourth cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ins_r <= 2'h0;
			instr_done <= 1'b0;
		end else begin
			ins_r <= ins_r + 2'h1;
			instr_done <= ins_r == 2'h3;
		end
	end
endmodule : core_fetch_model
`default_nettype wire

/* sim/vec_addr_gen_tb_top.sv */
// testbench: vector address generator against a queue scoreboard
`timescale 1ns/10ps
`default_nettype none
module vec_addr_gen_tb_top;
	import vec_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
	logic fuse = 1'b1, global_irq_flag = 1'b1, fetch_reset = 1'b0, irq_take, instr_done, eager = 1'b0;
	logic fetch_valid, irq_pending, irq_blocked;
	logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
	logic [11:0] boot = 12'h000, fetch_addr;
	logic [17:0] irq_request = '0, irq_enable = '1;
	logic [4:0] vector_number;
	logic [16:0] q[$];
	int n_fail = 0, comparisons = 0, nfetch = 0, sel = 0;
	initial begin
		forever #4 pclk = ~pclk;
	end
	vec_addr_gen u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.boot_reset_select_fuse(fuse), .boot_start_addr(boot), .irq_request, .irq_enable, .global_irq_flag,
		.fetch_reset, .irq_take, .instr_done, .fetch_addr, .fetch_valid, .vector_number, .irq_pending, .irq_blocked);
	core_fetch_model u_core (.pclk, .presetn, .irq_pending, .eager, .irq_take, .instr_done);
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task summarize;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize
	// each fetch must match the oldest expectation
	always @(posedge pclk) begin
		if (presetn && fetch_valid === 1'b1) begin
			nfetch++;
			if (q.size() == 0) chk("spare fetch", 32'h0, 32'h1);
			else chk("fetch", 32'(q.pop_front()), {15'h0, fetch_addr, vector_number});
		end
	end
	task wait_fetch(input int n0);
		for (int i = 0; i < 60 && nfetch == n0; i++) @(posedge pclk);
		if (nfetch == n0) begin
			chk("fetch timeout", 32'h1, 32'h0);
			summarize();
		end
	endtask : wait_fetch
	task reset_dut(input logic f, input logic [11:0] b);
		presetn <= 1'b0;
		fuse <= f;
		boot <= b;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask : reset_dut
	task reset_vec(input logic [11:0] e);
		int n0;
		n0 = nfetch;
		q.push_back({e, 5'h01});
		fetch_reset <= 1'b1;
		@(posedge pclk);
		fetch_reset <= 1'b0;
		wait_fetch(n0);
	endtask : reset_vec
	task vec(input logic [17:0] r, input logic [17:0] en);
		int k;
		int n0;
		k = 0;
		n0 = nfetch;
		while (k < 18 && !(r[k] && en[k])) k++;
		if (k == 18) return;
		q.push_back({12'(sel * boot + k + 1), 5'(k + 2)});
		irq_request <= r;
		irq_enable <= en;
		wait_fetch(n0);
		irq_request <= '0;
		repeat (6) @(posedge pclk);
	endtask : vec
	// holds the request until pready is sampled; more keeps psel for a back-to-back transfer
	task apb(input logic w, input logic [31:0] d, input logic more);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= 32'(REG_IRQ_CTRL);
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (int i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (pready !== 1'b1) begin
			chk("apb timeout", 32'h1, 32'h0);
			summarize();
		end
		rd = prdata;
		err = pslverr;
		penable <= 1'b0;
		if (!more) begin
			psel <= 1'b0;
			@(posedge pclk);
		end
	endtask : apb
	initial begin
		void'($urandom(28337));
		reset_dut(1'b1, 12'($urandom_range(12'hF00)));
		reset_vec(12'h000);
		for (int k = 0; k < 18; k++) vec(18'h1 << k, '1);
		repeat (8) vec(18'($urandom), 18'($urandom));
		$display("test table done");
		apb(1'b1, 32'h2, 1'b0);
		apb(1'b0, 32'h0, 1'b0);
		chk("ctrl unarmed", 32'h0, rd);
		apb(1'b1, 32'h1, 1'b0);
		repeat (6) @(posedge pclk);
		apb(1'b0, 32'h0, 1'b0);
		chk("ctrl expired", 32'h0, rd);
		eager <= 1'b1;
		repeat (6) @(posedge pclk);
		apb(1'b1, 32'h1, 1'b1);
		apb(1'b1, 32'h2, 1'b0);
		eager <= 1'b0;
		apb(1'b0, 32'h0, 1'b0);
		chk("ctrl moved", 32'h2, rd);
		chk("ctrl slverr", 32'h0, {31'h0, err});
		sel = 1;
		repeat (8) @(posedge pclk);
		for (int k = 0; k < 18; k++) vec(18'h1 << k, '1);
		$display("test moved done");
		reset_dut(1'b0, 12'($urandom_range(12'hF00)));
		sel = 0;
		reset_vec(boot);
		for (int k = 0; k < 3; k++) vec(18'h1 << k, '1);
		$display("test boot done");
		summarize();
	end
endmodule : vec_addr_gen_tb_top
`default_nettype wire
